/* File: dv/mmesp_chk.sv */
// Concurrent checks on the debug port top-level pins
`timescale 1ns/1ps
`default_nettype none
module mmesp_chk #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic shared_serial_pin_out,
  input wire logic shared_serial_pin_oe_n,
  input wire logic config_pins_released,
  input wire logic monitor_active,
  input wire logic irq_function_en,
  input wire logic watchdog_timer_disable,
  input wire logic software_interrupt_instruction_to_monitor,
  input wire logic flash_protect_bypass,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Frame is ten bits; slow divider doubles the bit time
  localparam int F1 = 10 * BIT_CYCLES;
  localparam int F2 = 20 * BIT_CYCLES;
  logic [15:0] low_cnt_ff;
  // ==========================================================
  // Drive length counter
  always_ff @(posedge clk) begin
    if (!nrst || shared_serial_pin_oe_n)
      low_cnt_ff <= 16'h0000;
    else
      low_cnt_ff <= low_cnt_ff + 16'h0001;
  end
  // ==========================================================
  // Assertions
  // protection follows monitor
  a_prot_follow_mon:
    assert property (watchdog_timer_disable == monitor_active
      && software_interrupt_instruction_to_monitor == monitor_active)
    else $error("protection disables differ from monitor state");
  a_bypass_needs_mon:
    assert property (flash_protect_bypass |-> monitor_active)
    else $error("flash bypass outside monitor mode");
  a_irq_outside_mon:
    assert property (!monitor_active [*2] |-> irq_function_en)
    else $error("interrupt function off outside monitor mode");
  a_cfg_released:
    assert property (monitor_active |-> config_pins_released)
    else $error("config pins held while in monitor mode");
  a_start_bit:
    assert property ($fell(shared_serial_pin_oe_n) && monitor_active |-> !shared_serial_pin_out)
    else $error("reply did not begin with a low start bit");
  a_reply_len:
    assert property ($rose(shared_serial_pin_oe_n) && monitor_active
      |-> low_cnt_ff inside {[F1-2:F1+2], [F2-2:F2+2]})
    else $error("pin driven for other than one frame");
  a_b_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before handshake");
  a_aw_blocked:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during pending response");
  a_r_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before handshake");
  c_entry: cover property ($rose(monitor_active));
  c_reply: cover property ($rose(shared_serial_pin_oe_n) && monitor_active);
  c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b10);
endmodule
`default_nettype wire

/* File: dv/mmesp_host.sv */
// Host serial port model seen through the translating pod
`timescale 1ns/1ps
`default_nettype none
module mmesp_host #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic line,
  output logic drv_en,
  output logic drv
);
  initial begin
    drv_en = 1'b0;
    drv = 1'b1;
  end
  task automatic send(input logic [7:0] b, input logic stop, input int gap);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    repeat (gap) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      drv_en <= 1'b1;
      drv <= f[i];
      repeat (BIT) @(posedge clk);
    end
    drv_en <= 1'b0;
    drv <= 1'b1;
    @(posedge clk);
  endtask
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (line !== 1'b0 && n < 40 * BIT) begin
      @(posedge clk);
      n++;
    end
    if (n < 40 * BIT) begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk);
        b[i] = line;
      end
      repeat (BIT) @(posedge clk);
      ok = (line === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the monitor-mode debug port
`timescale 1ns/1ps
`default_nettype none
module testbench import mmesp_pkg::*;;
  localparam int BC = 16;
  logic clk = 1'b0, nrst = 1'b0, hv = 1'b0, rp = 1'b0, rphv = 1'b0;
  logic ml = 1'b0, mh = 1'b0, dv = 1'b0, ss = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] pdat = SEC_CODE_DEF, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic pin_out, oe_n, h_en, h_drv, cfg, mon, cond, irq, wd, software_interrupt_instruction, fpb, awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_count = 0;
  int checks_done = 0;
  // Pull-up holds the line when nobody drives
  wire line = !oe_n ? pin_out : (h_en ? h_drv : 1'b1);
  always #10 clk = ~clk;
  mmesp_top #(.BIT_CYCLES(BC)) dut (
    .clk(clk), .nrst(nrst), .test_high_voltage(hv), .reset_pin(rp), .reset_pin_high_voltage(rphv),
    .mode_select_low(ml), .mode_select_high(mh), .bus_divider_select(dv), .security_select(ss),
    .security_parallel_data(pdat), .shared_serial_pin_in(line), .shared_serial_pin_out(pin_out),
    .shared_serial_pin_oe_n(oe_n), .config_pins_released(cfg), .monitor_active(mon),
    .monitor_conditions_en(cond), .irq_function_en(irq), .watchdog_timer_disable(wd),
    .software_interrupt_instruction_to_monitor(software_interrupt_instruction), .flash_protect_bypass(fpb),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr)
  );
  mmesp_host #(.BIT(BC)) host (.clk(clk), .line(line), .drv_en(h_en), .drv(h_drv));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Pin order {hv, ml, mh, dv, ss, rp}
  task automatic do_reset(input logic [5:0] c);
    nrst <= 1'b0;
    rphv <= 1'b0;
    // pins valid before reset pin rises
    {hv, ml, mh, dv, ss, rp} <= c;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic rise_rp();
    rp <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk);
      if (!a_ok && awr) begin
        a_ok = 1'b1;
        awv <= 1'b0;
      end
      if (!w_ok && wr) begin
        w_ok = 1'b1;
        wv <= 1'b0;
      end
    end
    br <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    chk("bresp", {30'h0, e}, {30'h0, bresp});
    br <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    rr <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    rr <= 1'b0;
  endtask
  task automatic mon_wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] f [4];
    f = '{CMD_WRITE, a[15:8], a[7:0], d};
    foreach (f[i]) host.send(f[i], 1'b1, 0);
  endtask
  task automatic mon_rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] b;
    logic ok;
    host.send(CMD_READ, 1'b1, 0);
    host.send(a[15:8], 1'b1, 0);
    host.send(a[7:0], 1'b1, BC);
    host.recv(b, ok);
    chk("reply", {24'h0, e}, {24'h0, b});
    chk("reply_stop", 32'h1, {31'h0, ok});
    repeat (BC) @(posedge clk);
    chk("oe_n_after_reply", 32'h1, {31'h0, oe_n});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_no_entry();
    logic [5:0] c [3];
    c = '{6'b001110, 6'b111110, 6'b101111};
    foreach (c[i]) begin
      do_reset(c[i]);
      rise_rp();
      chk("mon_no_entry", 32'h0, {31'h0, mon});
      chk("oe_n_idle", 32'h1, {31'h0, oe_n});
      chk("irq_idle", 32'h1, {31'h0, irq});
    end
  endtask
  task automatic t_entry();
    do_reset(6'b101110);
    chk("cond", 32'h1, {31'h0, cond});
    rise_rp();
    chk("mon", 32'h1, {31'h0, mon});
    chk("cfg", 32'h1, {31'h0, cfg});
    chk("wd_swi", 32'h3, {30'h0, wd, software_interrupt_instruction});
    chk("irq_mon", 32'h0, {31'h0, irq});
    chk("fpb_unsecured", 32'h0, {31'h0, fpb});
    axi_rd(REG_STATUS, 32'h0e7, RESP_OKAY);
    {ml, mh, dv, ss} <= 4'b1000;
    repeat (8) @(posedge clk);
    chk("mon_pins_free", 32'h1, {31'h0, mon});
  endtask
  task automatic t_serial();
    host.send(SEC_CODE_DEF, 1'b1, 3 * BC);
    repeat (4) @(posedge clk);
    chk("fpb_secured", 32'h1, {31'h0, fpb});
    mon_wr(16'h0003, 8'hab);
    mon_wr(16'h000f, 8'h5c);
    mon_rd(16'h0003, 8'hab);
    mon_rd(16'h000f, 8'h5c);
    host.send(8'h00, 1'b0, 0);
    repeat (2 * BC) @(posedge clk);
    mon_rd(MON_STAT_ADDR, 8'h77);
    axi_rd(REG_STATUS, 32'h1ef, RESP_OKAY);
    rphv <= 1'b1;
    repeat (8) @(posedge clk);
    chk("irq_restored", 32'h1, {31'h0, irq});
  endtask
  task automatic t_exit();
    logic [31:0] d [3];
    logic [1:0] e [3];
    d = '{32'h2, 32'h3, 32'h0};
    e = '{2'b00, 2'b01, 2'b11};
    axi_wr(REG_CTRL, 32'h4, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk("mon_exit", 32'h0, {31'h0, mon});
    foreach (d[i]) begin
      axi_wr(REG_CTRL, d[i], RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("port_pin", {30'h0, e[i]}, {30'h0, oe_n, oe_n ? e[i][0] : pin_out});
    end
    axi_rd(8'h08, 32'h0, RESP_SLVERR);
    axi_wr(8'h0c, 32'h4, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'h0, RESP_OKAY);
  endtask
  task automatic t_parallel();
    do_reset(6'b101100);
    rise_rp();
    chk("fpb_parallel", 32'h1, {31'h0, fpb});
    mon_rd(MON_STAT_ADDR, 8'h35);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    t_no_entry();
    t_entry();
    t_serial();
    t_exit();
    t_parallel();
    test_done();
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule
bind mmesp_top mmesp_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
  .clk(clk), .nrst(nrst), .shared_serial_pin_out(shared_serial_pin_out),
  .shared_serial_pin_oe_n(shared_serial_pin_oe_n), .config_pins_released(config_pins_released),
  .monitor_active(monitor_active), .irq_function_en(irq_function_en),
  .watchdog_timer_disable(watchdog_timer_disable),
  .software_interrupt_instruction_to_monitor(software_interrupt_instruction_to_monitor),
  .flash_protect_bypass(flash_protect_bypass), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

/* File: rtl/mmesp_pkg.sv */
// Constants for the monitor-mode entry and single-pin serial debug port
package mmesp_pkg;
  // ==========================================================
  // Clock and serial timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_RATE = 9600;
  // Bit time in clocks, rounded down
  localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_RATE;
  localparam int CNT_W = 16;
  // ==========================================================
  // Mode entry
  localparam logic MODE_LOW_REQ = 1'b0;
  localparam logic MODE_HIGH_REQ = 1'b1;
  localparam logic SSEL_SERIAL = 1'b1;
  localparam logic BUS_DIVIDER_SELECT_SET = 1'b1;
  // Arbitrary neutral security code
  localparam logic [7:0] SEC_CODE_DEF = 8'h5a;
  // ==========================================================
  // Monitor commands and monitor address map
  localparam logic [7:0] CMD_READ = 8'h4a;
  localparam logic [7:0] CMD_WRITE = 8'h49;
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW = 4;
  localparam logic [15:0] MON_STAT_ADDR = 16'h0010;
  // ==========================================================
  // Register bus map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  // Control bits
  localparam int CTRL_PIN_OUT = 0;
  localparam int CTRL_PIN_DRIVE = 1;
  localparam int CTRL_EXIT = 2;
  // Status bits
  localparam int ST_MON = 0;
  localparam int ST_BUS_DIVIDER_SELECT = 1;
  localparam int ST_SSEL = 2;
  localparam int ST_SECURED = 3;
  localparam int ST_IRQ_FN = 4;
  localparam int ST_HV = 5;
  localparam int ST_LATCHED = 6;
  localparam int ST_PIN_IN = 7;
  localparam int ST_FRAME_ERR = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ==========================================================
  // Synchronised input vector positions
  localparam int SY_HV = 0;
  localparam int SY_RST = 1;
  localparam int SY_MLOW = 2;
  localparam int SY_MHIGH = 3;
  localparam int SY_DIV = 4;
  localparam int SY_SSEL = 5;
  localparam int SY_RSTHV = 6;
  localparam int SY_RX = 7;
  localparam int SY_PAR = 8;
  localparam int SY_W = 16;
endpackage

/* File: rtl/mmesp_top.sv */
// Monitor-mode entry logic and half-duplex single-pin serial debug port
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser
module mmesp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

// ==========================================================
// Top
module mmesp_top import mmesp_pkg::*; #(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF,
  parameter logic [7:0] SEC_CODE = SEC_CODE_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic test_high_voltage,
  input wire logic reset_pin,
  input wire logic reset_pin_high_voltage,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic bus_divider_select,
  input wire logic security_select,
  input wire logic [7:0] security_parallel_data,
  input wire logic shared_serial_pin_in,
  output logic shared_serial_pin_out,
  output logic shared_serial_pin_oe_n,
  output logic config_pins_released,
  output logic monitor_active,
  output logic monitor_conditions_en,
  output logic irq_function_en,
  output logic watchdog_timer_disable,
  output logic software_interrupt_instruction_to_monitor,
  output logic flash_protect_bypass,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [2:0] {SR_OFF, SR_IDLE, SR_START, SR_DATA, SR_STOP, SR_TX} mmesp_ser_t;
  typedef enum logic [2:0] {PR_SEC, PR_CMD, PR_AHI, PR_ALO, PR_WDAT} mmesp_prs_t;

  // ==========================================================
  // Input synchronisation
  logic [SY_W-1:0] sy;
  logic rst_pin_d_ff;
  mmesp_sync #(.W(SY_W)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({security_parallel_data, shared_serial_pin_in, reset_pin_high_voltage, security_select,
        bus_divider_select, mode_select_high, mode_select_low, reset_pin, test_high_voltage}),
    .q(sy)
  );
  logic rx_s;
  logic rst_rise;
  assign rx_s = sy[SY_RX];
  assign rst_rise = sy[SY_RST] && !rst_pin_d_ff;

  // ==========================================================
  // Mode latch
  logic por_pend_ff, mon_ff, latched_ff, bus_divider_select_ff, ssel_ff, irq_rest_ff;
  logic [1:0] settle_ff;
  logic exit_req;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_pin_d_ff <= 1'b1;
      settle_ff <= '0;
      por_pend_ff <= 1'b1;
      mon_ff <= 1'b0;
      latched_ff <= 1'b0;
      bus_divider_select_ff <= 1'b0;
      ssel_ff <= 1'b0;
      irq_rest_ff <= 1'b0;
    end else begin
      settle_ff <= {settle_ff[0], 1'b1};
      // Synchroniser reset value is no pin edge
      // real edge needed
      rst_pin_d_ff <= sy[SY_RST] || !settle_ff[1];
      if (rst_rise && por_pend_ff) begin
        por_pend_ff <= 1'b0;
        latched_ff <= 1'b1;
        mon_ff <= sy[SY_HV] && (sy[SY_MLOW] == MODE_LOW_REQ) && (sy[SY_MHIGH] == MODE_HIGH_REQ);
        bus_divider_select_ff <= sy[SY_DIV];
        ssel_ff <= sy[SY_SSEL];
      end else if (exit_req) begin
        mon_ff <= 1'b0;
      end
      if (!mon_ff) begin
        irq_rest_ff <= 1'b0;
      end else if (sy[SY_RSTHV]) begin
        irq_rest_ff <= 1'b1;
      end
    end
  end

  logic [CNT_W-1:0] bit_len;
  logic [CNT_W-1:0] half_len;
  // Reload runs one cycle past zero
  assign bit_len = (bus_divider_select_ff == BUS_DIVIDER_SELECT_SET) ? CNT_W'(BIT_CYCLES - 1) : CNT_W'(2 * BIT_CYCLES - 1);
  assign half_len = {1'b0, bit_len[CNT_W-1:1]};

  // ==========================================================
  // Serial engine
  mmesp_ser_t ser_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [3:0] idx_ff;
  logic [7:0] rx_sh_ff;
  logic [9:0] tx_sh_ff;
  logic rx_done_ff, frame_err_ff;
  logic tx_req_ff;
  logic [7:0] tx_byte_ff;
  logic tx_take;
  logic cnt_zero;
  assign cnt_zero = (cnt_ff == '0);
  assign tx_take = (ser_ff == SR_IDLE) && tx_req_ff && cnt_zero;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ser_ff <= SR_OFF;
      cnt_ff <= '0;
      idx_ff <= '0;
      rx_sh_ff <= '0;
      tx_sh_ff <= '1;
      rx_done_ff <= 1'b0;
      frame_err_ff <= 1'b0;
    end else begin
      rx_done_ff <= 1'b0;
      if (!cnt_zero) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
      if (!mon_ff) begin
        ser_ff <= SR_OFF;
      end else begin
        case (ser_ff)
          SR_OFF: begin
            ser_ff <= SR_IDLE;
          end
          SR_IDLE: begin
            if (tx_take) begin
              tx_sh_ff <= {1'b1, tx_byte_ff, 1'b0};
              cnt_ff <= bit_len;
              idx_ff <= '0;
              ser_ff <= SR_TX;
            end else if (!rx_s) begin
              cnt_ff <= half_len;
              ser_ff <= SR_START;
            end
          end
          SR_START: begin
            if (cnt_zero) begin
              // Short low pulses are treated as noise
              ser_ff <= rx_s ? SR_IDLE : SR_DATA;
              cnt_ff <= bit_len;
              idx_ff <= '0;
            end
          end
          SR_DATA: begin
            if (cnt_zero) begin
              rx_sh_ff <= {rx_s, rx_sh_ff[7:1]};
              cnt_ff <= bit_len;
              idx_ff <= idx_ff + 1'b1;
              if (idx_ff == 4'h7) begin
                ser_ff <= SR_STOP;
              end
            end
          end
          SR_STOP: begin
            if (cnt_zero) begin
              rx_done_ff <= rx_s;
              frame_err_ff <= frame_err_ff | !rx_s;
              // Host stop bit ends before any reply
              cnt_ff <= half_len;
              ser_ff <= SR_IDLE;
            end
          end
          SR_TX: begin
            if (cnt_zero) begin
              tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
              cnt_ff <= bit_len;
              idx_ff <= idx_ff + 1'b1;
              if (idx_ff == 4'h9) begin
                ser_ff <= SR_IDLE;
              end
            end
          end
          default: begin
            ser_ff <= SR_OFF;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Command parser and monitor memory
  mmesp_prs_t prs_ff;
  logic secured_ff, is_read_ff;
  logic [15:0] addr_ff;
  logic [7:0] mem_ff [MEM_DEPTH];
  logic [7:0] stat_byte;
  logic [7:0] mon_rdata;
  logic [15:0] full_addr;
  assign stat_byte = {1'b0, frame_err_ff, latched_ff, sy[SY_HV], irq_rest_ff, secured_ff, ssel_ff, bus_divider_select_ff};
  assign full_addr = {addr_ff[15:8], rx_sh_ff};

  always_comb begin
    mon_rdata = 8'h00;
    if (full_addr < 16'(MEM_DEPTH)) begin
      mon_rdata = mem_ff[full_addr[MEM_AW-1:0]];
    end else if (full_addr == MON_STAT_ADDR) begin
      mon_rdata = stat_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prs_ff <= PR_SEC;
      secured_ff <= 1'b0;
      is_read_ff <= 1'b0;
      addr_ff <= '0;
      tx_req_ff <= 1'b0;
      tx_byte_ff <= '0;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_ff[i] <= 8'h00;
      end
    end else begin
      if (tx_take) begin
        tx_req_ff <= 1'b0;
      end
      if (!mon_ff) begin
        prs_ff <= PR_SEC;
        secured_ff <= 1'b0;
      end else if (prs_ff == PR_SEC && ssel_ff != SSEL_SERIAL) begin
        secured_ff <= (sy[SY_PAR+:8] == SEC_CODE);
        prs_ff <= PR_CMD;
      end else if (rx_done_ff) begin
        case (prs_ff)
          PR_SEC: begin
            if (rx_sh_ff == SEC_CODE) begin
              secured_ff <= 1'b1;
              prs_ff <= PR_CMD;
            end
          end
          PR_CMD: begin
            if (rx_sh_ff == CMD_READ || rx_sh_ff == CMD_WRITE) begin
              is_read_ff <= (rx_sh_ff == CMD_READ);
              prs_ff <= PR_AHI;
            end
          end
          PR_AHI: begin
            addr_ff[15:8] <= rx_sh_ff;
            prs_ff <= PR_ALO;
          end
          PR_ALO: begin
            addr_ff[7:0] <= rx_sh_ff;
            if (is_read_ff) begin
              tx_byte_ff <= secured_ff ? mon_rdata : 8'h00;
              tx_req_ff <= 1'b1;
              prs_ff <= PR_CMD;
            end else begin
              prs_ff <= PR_WDAT;
            end
          end
          PR_WDAT: begin
            if (secured_ff && addr_ff < 16'(MEM_DEPTH)) begin
              mem_ff[addr_ff[MEM_AW-1:0]] <= rx_sh_ff;
            end
            prs_ff <= PR_CMD;
          end
          default: begin
            prs_ff <= PR_CMD;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register bus
  logic aw_got_ff, w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_fire;
  logic pin_out_ff, pin_drive_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign exit_req = wr_fire && awaddr_ff == REG_CTRL && wstrb_ff[0] && wdata_ff[CTRL_EXIT];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
        aw_got_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!aw_got_ff && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_got_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!w_got_ff && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_ff == REG_CTRL || awaddr_ff == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; exit bit is a write pulse only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_out_ff <= 1'b1;
      pin_drive_ff <= 1'b0;
    end else if (wr_fire && awaddr_ff == REG_CTRL && wstrb_ff[0]) begin
      pin_out_ff <= wdata_ff[CTRL_PIN_OUT];
      pin_drive_ff <= wdata_ff[CTRL_PIN_DRIVE];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) begin
        s_axi_rdata[CTRL_PIN_OUT] <= pin_out_ff;
        s_axi_rdata[CTRL_PIN_DRIVE] <= pin_drive_ff;
      end else if (s_axi_araddr == REG_STATUS) begin
        s_axi_rdata[ST_MON] <= mon_ff;
        s_axi_rdata[ST_BUS_DIVIDER_SELECT] <= bus_divider_select_ff;
        s_axi_rdata[ST_SSEL] <= ssel_ff;
        s_axi_rdata[ST_SECURED] <= secured_ff;
        s_axi_rdata[ST_IRQ_FN] <= !mon_ff || irq_rest_ff;
        s_axi_rdata[ST_HV] <= sy[SY_HV];
        s_axi_rdata[ST_LATCHED] <= latched_ff;
        s_axi_rdata[ST_PIN_IN] <= rx_s;
        s_axi_rdata[ST_FRAME_ERR] <= frame_err_ff;
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Pin and mode outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shared_serial_pin_out <= 1'b1;
      shared_serial_pin_oe_n <= 1'b1;
      config_pins_released <= 1'b0;
      monitor_active <= 1'b0;
      monitor_conditions_en <= 1'b0;
      irq_function_en <= 1'b1;
      watchdog_timer_disable <= 1'b0;
      software_interrupt_instruction_to_monitor <= 1'b0;
      flash_protect_bypass <= 1'b0;
    end else begin
      if (mon_ff) begin
        shared_serial_pin_out <= (ser_ff == SR_TX) ? tx_sh_ff[0] : 1'b1;
        shared_serial_pin_oe_n <= (ser_ff != SR_TX);
      end else begin
        shared_serial_pin_out <= pin_out_ff;
        shared_serial_pin_oe_n <= !pin_drive_ff;
      end
      config_pins_released <= latched_ff;
      monitor_active <= mon_ff;
      monitor_conditions_en <= sy[SY_HV] && por_pend_ff;
      irq_function_en <= !mon_ff || irq_rest_ff;
      watchdog_timer_disable <= mon_ff;
      software_interrupt_instruction_to_monitor <= mon_ff;
      flash_protect_bypass <= mon_ff && secured_ff;
    end
  end
endmodule

`default_nettype wire
